//--- src/argc_regs.sv
// Notes on behaviour
// - mode register bit 4 selects capless headphones
// - mode 0 shuts down every output
// - earpiece and speaker enable bits switch outputs
// - headphone enables; capless and off means mute
// - line exclusive enables only line inputs
// - pcm exclusive enables only converter inputs
// - mono exclusive enables mono mux, drops headphone
// - headphone exclusive enables only headphone mux
// - 5-bit level codes follow step table
// - line trims -6 to +15 dB
// - voice trim -12 to +9 dB
// - converter trims -3 to +6 dB
// - halve bit divides master clock by two
// - source bit picks master or serial clock
// - core clock from synth input or output
// - synth enable effective only in modes 4-7
// - prescale divide 1 to 8 in halves
// - oversampling codes give 125, 128, 64, 32
// - reference divider off at zero, (code+1)/2
// - feedback integer off at zero, min 10
// - post divider off at zero, (code+1)/2
// - fraction adds code/32 to feedback
// - 8-bit write-only registers, device is slave
// - all registers clear to zero at reset
`timescale 1ns/1ps
module argc_regs
  import argc_pkg::*;
(
  input  wire logic       CORE_CLK,
  input  wire logic       RESET,
  input  wire logic       SPI_ENB_N,
  input  wire logic       SPI_SCK,
  input  wire logic       SPI_SDI,
  output logic [2:0]      MIXER_MODE,
  output logic            CAPLESS_HP_SELECT,
  output logic            CAP_COUPLED_OUT,
  output logic            EARPIECE_ON,
  output logic            SPEAKER_ON,
  output logic            HEADPHONE_LEFT_ON,
  output logic            HEADPHONE_RIGHT_ON,
  output logic            HEADPHONE_LEFT_MUTE,
  output logic            HEADPHONE_RIGHT_MUTE,
  output logic            MONO_IN_ON,
  output logic            LINE_IN_LEFT_ON,
  output logic            LINE_IN_RIGHT_ON,
  output logic            PCM_LEFT_CH_ON,
  output logic            PCM_RIGHT_CH_ON,
  output logic            MONO_MUX_ON,
  output logic            HP_MUX_ON,
  output logic [7:0]      EARPIECE_LEVEL_DB,
  output logic [7:0]      SPEAKER_LEVEL_DB,
  output logic [7:0]      HEADPHONE_LEFT_LEVEL_DB,
  output logic [7:0]      HEADPHONE_RIGHT_LEVEL_DB,
  output logic [7:0]      LINE_LEFT_TRIM_DB,
  output logic [7:0]      LINE_RIGHT_TRIM_DB,
  output logic [7:0]      VOICE_TRIM_DB,
  output logic [7:0]      PCM_LEFT_TRIM_DB,
  output logic [7:0]      PCM_RIGHT_TRIM_DB,
  output logic            MCLK_HALVE,
  output logic            SYNTH_SRC_ASI_CLK,
  output logic            CORE_CLK_FROM_SYNTH,
  output logic            SYNTH_ENABLE,
  output logic [4:0]      PRESCALE_HALVES,
  output logic            SYNTH_REF_OFF,
  output logic [7:0]      SYNTH_REF_HALVES,
  output logic            SYNTH_FB_OFF,
  output logic [7:0]      SYNTH_FB_INT,
  output logic [4:0]      SYNTH_FRACTION,
  output logic            SYNTH_POST_OFF,
  output logic [4:0]      SYNTH_POST_HALVES,
  output logic [7:0]      OSR_RATIO
);

  // ---------------------------------------------------------------
  // serial control port
  // ---------------------------------------------------------------
  argc_spi_state_t state_ff, nxt_state;
  logic [3:0]      cnt_ff, nxt_cnt;
  logic [15:0]     shift_ff, nxt_shift;
  logic            sck_prev_ff, nxt_sck_prev;
  logic            sck_rise;
  logic            wr_fire;
  logic [15:0]     frame;

  assign sck_rise = SPI_SCK & ~sck_prev_ff;
  assign frame    = {shift_ff[ARGC_FRAME_BITS-2:0], SPI_SDI};

  always_comb begin
    nxt_state    = state_ff;
    nxt_cnt      = cnt_ff;
    nxt_shift    = shift_ff;
    nxt_sck_prev = SPI_SCK;
    wr_fire      = 1'b0;
    if (SPI_ENB_N) begin
      nxt_state = ARGC_IDLE;
      nxt_cnt   = '0;
    end else begin
      case (state_ff)
        ARGC_IDLE, ARGC_SHIFT: begin
          nxt_state = ARGC_SHIFT;
          if (sck_rise) begin
            nxt_shift = frame;
            if (cnt_ff == ARGC_CNT_LAST) begin
              wr_fire   = 1'b1;
              nxt_state = ARGC_WAIT;
            end else begin
              nxt_cnt = 4'(cnt_ff + ARGC_CNT_ONE);
            end
          end
        end
        ARGC_WAIT: begin
          nxt_state = ARGC_WAIT;
        end
        default: begin
          nxt_state = ARGC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      state_ff    <= ARGC_IDLE;
      cnt_ff      <= '0;
      shift_ff    <= '0;
      sck_prev_ff <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      cnt_ff      <= nxt_cnt;
      shift_ff    <= nxt_shift;
      sck_prev_ff <= nxt_sck_prev;
    end
  end

  // ---------------------------------------------------------------
  // write-only register file
  // ---------------------------------------------------------------
  logic [7:0] regs_ff  [16];
  logic [7:0] nxt_regs [16];

  always_comb begin
    nxt_regs = regs_ff;
    if (wr_fire && argc_mapped(frame[15:8])) begin
      nxt_regs[frame[11:8]] = frame[7:0];
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      for (int i = 0; i < 16; i++) begin
        regs_ff[i] <= ARGC_RESET_VAL;
      end
    end else begin
      regs_ff <= nxt_regs;
    end
  end

  // ---------------------------------------------------------------
  // field decode
  // ---------------------------------------------------------------
  logic [7:0] r_mode, r_out, r_vp, r_clk, r_line;
  logic       mv;
  logic [2:0] midx;
  logic       mono_mux, hp_mux, lx, px;
  logic       capless;

  assign r_mode  = regs_ff[ARGC_IDX_MODE];
  assign r_out   = regs_ff[ARGC_IDX_OUT];
  assign r_vp    = regs_ff[ARGC_IDX_VP];
  assign r_clk   = regs_ff[ARGC_IDX_CLK];
  assign r_line  = regs_ff[ARGC_IDX_LINE];
  assign mv      = r_mode[ARGC_MODE_VALID_BIT] & (r_mode[2:0] != 3'h0);
  assign midx    = mv ? r_mode[2:0] : 3'h0;
  assign capless = r_mode[ARGC_CAPLESS_BIT];
  assign lx      = r_out[ARGC_LINE_EXCL_BIT];
  assign px      = r_out[ARGC_PCM_EXCL_BIT];
  assign mono_mux = mv & (r_out[ARGC_MONO_EXCL_BIT] | ~r_out[ARGC_HP_EXCL_BIT]);
  assign hp_mux   = mv & ~r_out[ARGC_MONO_EXCL_BIT];

  // decoded outputs, one flop each
  logic [2:0] mode_ff;
  logic       capless_ff, cap_ff, ep_ff, ls_ff, hpl_ff, hpr_ff, hplm_ff, hprm_ff;
  logic       mono_in_ff, line_l_ff, line_r_ff, pcm_l_ff, pcm_r_ff, mmux_ff, hmux_ff;
  logic [7:0] ep_db_ff, ls_db_ff, hpl_db_ff, hpr_db_ff;
  logic [7:0] ll_db_ff, lr_db_ff, v_db_ff, pl_db_ff, pr_db_ff;
  logic       halve_ff, src_ff, core_ff, synth_ff, ref_off_ff, fb_off_ff, post_off_ff;
  logic [4:0] pre_ff, frac_ff, post_ff;
  logic [7:0] ref_ff, fb_ff, osr_ff;

  logic [2:0] nxt_mode;
  logic       nxt_capless, nxt_cap, nxt_ep, nxt_ls, nxt_hpl, nxt_hpr, nxt_hplm, nxt_hprm;
  logic       nxt_mono_in, nxt_line_l, nxt_line_r, nxt_pcm_l, nxt_pcm_r, nxt_mmux, nxt_hmux;
  logic [7:0] nxt_ep_db, nxt_ls_db, nxt_hpl_db, nxt_hpr_db;
  logic [7:0] nxt_ll_db, nxt_lr_db, nxt_v_db, nxt_pl_db, nxt_pr_db;
  logic       nxt_halve, nxt_src, nxt_core, nxt_synth, nxt_ref_off, nxt_fb_off, nxt_post_off;
  logic [4:0] nxt_pre, nxt_frac, nxt_post;
  logic [7:0] nxt_ref, nxt_fb, nxt_osr;

  always_comb begin
    nxt_mode     = midx;
    nxt_capless  = capless;
    nxt_cap      = ~capless;
    nxt_ep       = mono_mux & r_out[ARGC_EP_EN_BIT];
    nxt_ls       = mono_mux & r_out[ARGC_LS_EN_BIT];
    nxt_hpl      = hp_mux & r_out[ARGC_HPL_EN_BIT];
    nxt_hpr      = hp_mux & r_out[ARGC_HPR_EN_BIT];
    nxt_hplm     = hp_mux & capless & ~r_out[ARGC_HPL_EN_BIT];
    nxt_hprm     = hp_mux & capless & ~r_out[ARGC_HPR_EN_BIT];
    nxt_mono_in  = ARGC_MONO_MODES[midx] & ~lx & ~px;
    nxt_line_l   = mv & (lx | (~px & ARGC_LINE_MODES[midx]));
    nxt_line_r   = nxt_line_l;
    nxt_pcm_l    = mv & ~lx & (px | ARGC_PCM_MODES[midx]);
    nxt_pcm_r    = nxt_pcm_l;
    nxt_mmux     = mono_mux;
    nxt_hmux     = hp_mux;
    nxt_ep_db    = ARGC_VOL_DB[regs_ff[ARGC_IDX_EP][4:0]];
    nxt_ls_db    = ARGC_VOL_DB[regs_ff[ARGC_IDX_LS][4:0]];
    nxt_hpl_db   = ARGC_VOL_DB[regs_ff[ARGC_IDX_HPL][4:0]];
    nxt_hpr_db   = ARGC_VOL_DB[regs_ff[ARGC_IDX_HPR][4:0]];
    nxt_ll_db    = argc_trim_db(r_line[ARGC_TRIM_L_LSB +: 3], ARGC_LINE_OFFS);
    nxt_lr_db    = argc_trim_db(r_line[ARGC_TRIM_R_LSB +: 3], ARGC_LINE_OFFS);
    nxt_v_db     = argc_trim_db(r_vp[ARGC_TRIM_L_LSB +: 3], ARGC_VOICE_OFFS);
    nxt_pl_db    = argc_trim_db({1'b0, r_vp[ARGC_PCM_L_LSB +: 2]}, ARGC_PCM_OFFS);
    nxt_pr_db    = argc_trim_db({1'b0, r_vp[ARGC_PCM_R_LSB +: 2]}, ARGC_PCM_OFFS);
    nxt_halve    = r_clk[ARGC_HALVE_BIT];
    nxt_src      = r_clk[ARGC_SRC_BIT];
    nxt_core     = r_clk[ARGC_CORE_BIT];
    nxt_synth    = r_clk[ARGC_SYNTH_EN_BIT] & mv & (midx >= ARGC_SYNTH_MIN_MODE);
    nxt_pre      = (r_clk[ARGC_PRESCALE_LSB +: 4] <= ARGC_PRESCALE_FLOOR) ?
                   ARGC_PRESCALE_MIN : argc_halves(r_clk[ARGC_PRESCALE_LSB +: 4]);
    nxt_osr      = ARGC_OSR_TABLE[regs_ff[ARGC_IDX_DAC][1:0]];
    nxt_ref_off  = (regs_ff[ARGC_IDX_REF][6:0] == 7'h00);
    nxt_ref      = 8'({1'b0, regs_ff[ARGC_IDX_REF][6:0]} + 8'h01);
    nxt_fb_off   = (regs_ff[ARGC_IDX_FBI] == 8'h00);
    nxt_fb       = (regs_ff[ARGC_IDX_FBI] <= ARGC_FB_FLOOR) ?
                   ARGC_FB_FLOOR : regs_ff[ARGC_IDX_FBI];
    nxt_frac     = regs_ff[ARGC_IDX_FRAC][4:0];
    nxt_post_off = (regs_ff[ARGC_IDX_POST][3:0] == 4'h0);
    nxt_post     = argc_halves(regs_ff[ARGC_IDX_POST][3:0]);
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      mode_ff <= '0; capless_ff <= 1'b0; cap_ff <= 1'b1;
      ep_ff <= 1'b0; ls_ff <= 1'b0; hpl_ff <= 1'b0; hpr_ff <= 1'b0;
      hplm_ff <= 1'b0; hprm_ff <= 1'b0; mono_in_ff <= 1'b0;
      line_l_ff <= 1'b0; line_r_ff <= 1'b0; pcm_l_ff <= 1'b0; pcm_r_ff <= 1'b0;
      mmux_ff <= 1'b0; hmux_ff <= 1'b0;
      ep_db_ff <= ARGC_DB_MUTE; ls_db_ff <= ARGC_DB_MUTE;
      hpl_db_ff <= ARGC_DB_MUTE; hpr_db_ff <= ARGC_DB_MUTE;
      ll_db_ff <= ARGC_LINE_OFFS; lr_db_ff <= ARGC_LINE_OFFS; v_db_ff <= ARGC_VOICE_OFFS;
      pl_db_ff <= ARGC_PCM_OFFS; pr_db_ff <= ARGC_PCM_OFFS;
      halve_ff <= 1'b0; src_ff <= 1'b0; core_ff <= 1'b0; synth_ff <= 1'b0;
      pre_ff <= ARGC_PRESCALE_MIN; osr_ff <= ARGC_OSR_TABLE[0];
      ref_off_ff <= 1'b1; ref_ff <= 8'h01; fb_off_ff <= 1'b1; fb_ff <= ARGC_FB_FLOOR;
      frac_ff <= '0; post_off_ff <= 1'b1; post_ff <= 5'h01;
    end else begin
      mode_ff <= nxt_mode; capless_ff <= nxt_capless; cap_ff <= nxt_cap;
      ep_ff <= nxt_ep; ls_ff <= nxt_ls; hpl_ff <= nxt_hpl; hpr_ff <= nxt_hpr;
      hplm_ff <= nxt_hplm; hprm_ff <= nxt_hprm; mono_in_ff <= nxt_mono_in;
      line_l_ff <= nxt_line_l; line_r_ff <= nxt_line_r;
      pcm_l_ff <= nxt_pcm_l; pcm_r_ff <= nxt_pcm_r;
      mmux_ff <= nxt_mmux; hmux_ff <= nxt_hmux;
      ep_db_ff <= nxt_ep_db; ls_db_ff <= nxt_ls_db;
      hpl_db_ff <= nxt_hpl_db; hpr_db_ff <= nxt_hpr_db;
      ll_db_ff <= nxt_ll_db; lr_db_ff <= nxt_lr_db; v_db_ff <= nxt_v_db;
      pl_db_ff <= nxt_pl_db; pr_db_ff <= nxt_pr_db;
      halve_ff <= nxt_halve; src_ff <= nxt_src; core_ff <= nxt_core; synth_ff <= nxt_synth;
      pre_ff <= nxt_pre; osr_ff <= nxt_osr;
      ref_off_ff <= nxt_ref_off; ref_ff <= nxt_ref; fb_off_ff <= nxt_fb_off; fb_ff <= nxt_fb;
      frac_ff <= nxt_frac; post_off_ff <= nxt_post_off; post_ff <= nxt_post;
    end
  end

  // ---------------------------------------------------------------
  // port drive
  // ---------------------------------------------------------------
  assign MIXER_MODE = mode_ff;
  assign CAPLESS_HP_SELECT = capless_ff;
  assign CAP_COUPLED_OUT = cap_ff;
  assign EARPIECE_ON = ep_ff;
  assign SPEAKER_ON = ls_ff;
  assign HEADPHONE_LEFT_ON = hpl_ff;
  assign HEADPHONE_RIGHT_ON = hpr_ff;
  assign HEADPHONE_LEFT_MUTE = hplm_ff;
  assign HEADPHONE_RIGHT_MUTE = hprm_ff;
  assign MONO_IN_ON = mono_in_ff;
  assign LINE_IN_LEFT_ON = line_l_ff;
  assign LINE_IN_RIGHT_ON = line_r_ff;
  assign PCM_LEFT_CH_ON = pcm_l_ff;
  assign PCM_RIGHT_CH_ON = pcm_r_ff;
  assign MONO_MUX_ON = mmux_ff;
  assign HP_MUX_ON = hmux_ff;
  assign EARPIECE_LEVEL_DB = ep_db_ff;
  assign SPEAKER_LEVEL_DB = ls_db_ff;
  assign HEADPHONE_LEFT_LEVEL_DB = hpl_db_ff;
  assign HEADPHONE_RIGHT_LEVEL_DB = hpr_db_ff;
  assign LINE_LEFT_TRIM_DB = ll_db_ff;
  assign LINE_RIGHT_TRIM_DB = lr_db_ff;
  assign VOICE_TRIM_DB = v_db_ff;
  assign PCM_LEFT_TRIM_DB = pl_db_ff;
  assign PCM_RIGHT_TRIM_DB = pr_db_ff;
  assign MCLK_HALVE = halve_ff;
  assign SYNTH_SRC_ASI_CLK = src_ff;
  assign CORE_CLK_FROM_SYNTH = core_ff;
  assign SYNTH_ENABLE = synth_ff;
  assign PRESCALE_HALVES = pre_ff;
  assign SYNTH_REF_OFF = ref_off_ff;
  assign SYNTH_REF_HALVES = ref_ff;
  assign SYNTH_FB_OFF = fb_off_ff;
  assign SYNTH_FB_INT = fb_ff;
  assign SYNTH_FRACTION = frac_ff;
  assign SYNTH_POST_OFF = post_off_ff;
  assign SYNTH_POST_HALVES = post_ff;
  assign OSR_RATIO = osr_ff;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);

  a_capless_write: assert property (
    wr_fire && frame[15:8] == {ARGC_ADDR_HI, ARGC_IDX_MODE}
    |-> ##2 (CAPLESS_HP_SELECT == $past(frame[ARGC_CAPLESS_BIT], 2)) && (CAP_COUPLED_OUT != CAPLESS_HP_SELECT))
    else $error("capless select did not follow mode write");

  a_mode0_shut: assert property (
    !mv |=> !EARPIECE_ON && !SPEAKER_ON && !HEADPHONE_LEFT_ON && !HEADPHONE_RIGHT_ON)
    else $error("output active in mode 0");

  a_ep_enable: assert property (
    mono_mux |=> EARPIECE_ON == $past(r_out[ARGC_EP_EN_BIT]))
    else $error("earpiece does not follow enable");

  a_hp_mute: assert property (
    hp_mux && capless && !r_out[ARGC_HPL_EN_BIT] |=> HEADPHONE_LEFT_MUTE && !HEADPHONE_LEFT_ON)
    else $error("capless headphone left not muted");

  a_line_excl: assert property (
    mv && lx |=> LINE_IN_LEFT_ON && !PCM_LEFT_CH_ON && !MONO_IN_ON)
    else $error("line exclusive not honoured");

  a_mono_excl: assert property (
    mv && r_out[ARGC_MONO_EXCL_BIT] |=> MONO_MUX_ON && !HP_MUX_ON)
    else $error("mono exclusive not honoured");

  a_synth_gate: assert property (
    SYNTH_ENABLE |-> $past(r_clk[ARGC_SYNTH_EN_BIT]) && MIXER_MODE >= ARGC_SYNTH_MIN_MODE)
    else $error("synth enabled outside modes 4-7");

  a_fb_floor: assert property (
    !SYNTH_FB_OFF |-> SYNTH_FB_INT >= ARGC_FB_FLOOR)
    else $error("feedback divide below floor");

  a_write_latency: assert property (
    wr_fire && frame[15:8] == {ARGC_ADDR_HI, ARGC_IDX_CLK}
    |-> ##2 MCLK_HALVE == $past(frame[ARGC_HALVE_BIT], 2))
    else $error("clock halve late after write");

  c_write_done: cover property (wr_fire);
  c_hp_muted: cover property (HEADPHONE_LEFT_MUTE && HEADPHONE_RIGHT_MUTE);
  c_synth_on: cover property (SYNTH_ENABLE);
  c_line_only: cover property (LINE_IN_LEFT_ON && !MONO_IN_ON);

endmodule : argc_regs

//--- src/argc_pkg.sv
package argc_pkg;

  // ---------------------------------------------------------------
  // serial control port framing
  // ---------------------------------------------------------------
  localparam int          ARGC_FRAME_BITS = 16;
  localparam logic [3:0]  ARGC_CNT_LAST   = 4'hF;
  localparam logic [3:0]  ARGC_CNT_ONE    = 4'h1;
  localparam logic [3:0]  ARGC_ADDR_HI    = 4'h0;
  localparam logic [7:0]  ARGC_RESET_VAL  = 8'h00;

  // ---------------------------------------------------------------
  // register indices (low nibble of the 8-bit address)
  // ---------------------------------------------------------------
  localparam logic [3:0]  ARGC_IDX_MODE = 4'h0;
  localparam logic [3:0]  ARGC_IDX_OUT  = 4'h1;
  localparam logic [3:0]  ARGC_IDX_EP   = 4'h2;
  localparam logic [3:0]  ARGC_IDX_LS   = 4'h3;
  localparam logic [3:0]  ARGC_IDX_RSVD = 4'h4;
  localparam logic [3:0]  ARGC_IDX_HPL  = 4'h5;
  localparam logic [3:0]  ARGC_IDX_HPR  = 4'h6;
  localparam logic [3:0]  ARGC_IDX_LINE = 4'h7;
  localparam logic [3:0]  ARGC_IDX_VP   = 4'h8;
  localparam logic [3:0]  ARGC_IDX_CLK  = 4'h9;
  localparam logic [3:0]  ARGC_IDX_REF  = 4'hA;
  localparam logic [3:0]  ARGC_IDX_FBI  = 4'hB;
  localparam logic [3:0]  ARGC_IDX_FRAC = 4'hC;
  localparam logic [3:0]  ARGC_IDX_POST = 4'hD;
  localparam logic [3:0]  ARGC_IDX_DAC  = 4'hE;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int ARGC_MODE_VALID_BIT = 3;
  localparam int ARGC_CAPLESS_BIT    = 4;
  localparam int ARGC_EP_EN_BIT      = 0;
  localparam int ARGC_LS_EN_BIT      = 1;
  localparam int ARGC_HPL_EN_BIT     = 2;
  localparam int ARGC_HPR_EN_BIT     = 3;
  localparam int ARGC_LINE_EXCL_BIT  = 4;
  localparam int ARGC_PCM_EXCL_BIT   = 5;
  localparam int ARGC_MONO_EXCL_BIT  = 6;
  localparam int ARGC_HP_EXCL_BIT    = 7;
  localparam int ARGC_HALVE_BIT      = 0;
  localparam int ARGC_SRC_BIT        = 1;
  localparam int ARGC_CORE_BIT       = 2;
  localparam int ARGC_SYNTH_EN_BIT   = 3;
  localparam int ARGC_TRIM_L_LSB     = 0;
  localparam int ARGC_TRIM_R_LSB     = 3;
  localparam int ARGC_PCM_L_LSB      = 3;
  localparam int ARGC_PCM_R_LSB      = 5;
  localparam int ARGC_PRESCALE_LSB   = 4;

  // ---------------------------------------------------------------
  // mixer mode table, one bit per mode index
  // ---------------------------------------------------------------
  localparam logic [7:0] ARGC_MONO_MODES = 8'hCA;
  localparam logic [7:0] ARGC_LINE_MODES = 8'h6C;
  localparam logic [7:0] ARGC_PCM_MODES  = 8'hF0;
  localparam logic [2:0] ARGC_SYNTH_MIN_MODE = 3'h4;

  // ---------------------------------------------------------------
  // gain tables in signed dB, mute shown as ARGC_DB_MUTE
  // ---------------------------------------------------------------
  localparam logic [7:0] ARGC_DB_MUTE      = 8'h80;
  localparam logic [7:0] ARGC_TRIM_STEP    = 8'h03;
  localparam logic [7:0] ARGC_LINE_OFFS    = 8'hFA;
  localparam logic [7:0] ARGC_VOICE_OFFS   = 8'hF4;
  localparam logic [7:0] ARGC_PCM_OFFS     = 8'hFD;
  localparam logic [7:0] ARGC_VOL_DB [32] = '{
    8'h80, 8'hC8, 8'hCC, 8'hD0, 8'hD3, 8'hD6, 8'hD9, 8'hDC,
    8'hDF, 8'hE2, 8'hE4, 8'hE6, 8'hE8, 8'hEA, 8'hEC, 8'hEE,
    8'hF0, 8'hF2, 8'hF4, 8'hF6, 8'hF8, 8'hFA, 8'hFC, 8'hFD,
    8'hFE, 8'hFF, 8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05};

  // ---------------------------------------------------------------
  // divider and converter constants
  // ---------------------------------------------------------------
  localparam logic [3:0] ARGC_PRESCALE_FLOOR = 4'h1;
  localparam logic [4:0] ARGC_PRESCALE_MIN   = 5'h02;
  localparam logic [7:0] ARGC_FB_FLOOR       = 8'h0A;
  localparam logic [7:0] ARGC_OSR_TABLE [4]  = '{8'h7D, 8'h80, 8'h40, 8'h20};

  typedef enum logic [1:0] {
    ARGC_IDLE  = 2'b00,
    ARGC_SHIFT = 2'b01,
    ARGC_WAIT  = 2'b10
  } argc_spi_state_t;

  // ---------------------------------------------------------------
  // shared functions
  // ---------------------------------------------------------------
  function automatic logic argc_mapped(input logic [7:0] addr);
    argc_mapped = (addr[7:4] == ARGC_ADDR_HI) && (addr[3:0] != ARGC_IDX_RSVD) &&
                  (addr[3:0] <= ARGC_IDX_DAC);
  endfunction : argc_mapped

  function automatic logic [7:0] argc_trim_db(input logic [2:0] code,
                                              input logic [7:0] offs);
    logic [7:0] prod;
    prod = 8'({5'h00, code} * ARGC_TRIM_STEP);
    argc_trim_db = 8'(prod + offs);
  endfunction : argc_trim_db

  function automatic logic [4:0] argc_halves(input logic [3:0] code);
    argc_halves = 5'({1'b0, code} + 5'h01);
  endfunction : argc_halves

endpackage : argc_pkg

//--- dv/argc_spi_host.sv
`timescale 1ns/1ps
module argc_spi_host (
  input  wire logic clk,
  output logic      enb_n,
  output logic      sck,
  output logic      sdi
);
  // ----
  // serial host: 16-bit frames, msb first
  // ----
  initial begin
    enb_n = 1'b1;
    sck   = 1'b0;
    sdi   = 1'b0;
  end

  // fewer than 16 bits gives an aborted frame
  task automatic send(input logic [15:0] w, input int n);
    @(posedge clk);
    #1 enb_n = 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      @(posedge clk);
      #1 sck = 1'b0;
      sdi = w[i];
      @(posedge clk);
      #1 sck = 1'b1;
    end
    @(posedge clk);
    #1 sck = 1'b0;
    @(posedge clk);
    #1 enb_n = 1'b1;
    sdi = ~sdi;
  endtask : send
endmodule : argc_spi_host

//--- dv/tb_audio_route_gain_clock_regs.sv
`timescale 1ns/1ps
module tb_audio_route_gain_clock_regs
  import argc_pkg::*;
;
  // ----
  // signals and model
  // ----
  logic       CORE_CLK, RESET, SPI_ENB_N, SPI_SCK, SPI_SDI, CAPLESS_HP_SELECT, CAP_COUPLED_OUT;
  logic       EARPIECE_ON, SPEAKER_ON, HEADPHONE_LEFT_ON, HEADPHONE_RIGHT_ON, MONO_IN_ON;
  logic       HEADPHONE_LEFT_MUTE, HEADPHONE_RIGHT_MUTE, LINE_IN_LEFT_ON, LINE_IN_RIGHT_ON;
  logic       PCM_LEFT_CH_ON, PCM_RIGHT_CH_ON, MONO_MUX_ON, HP_MUX_ON, MCLK_HALVE;
  logic       SYNTH_SRC_ASI_CLK, CORE_CLK_FROM_SYNTH, SYNTH_ENABLE, SYNTH_REF_OFF;
  logic       SYNTH_FB_OFF, SYNTH_POST_OFF;
  logic [2:0] MIXER_MODE, md;
  logic [1:0] mx;
  logic [4:0] PRESCALE_HALVES, SYNTH_FRACTION, SYNTH_POST_HALVES, ins;
  logic [7:0] EARPIECE_LEVEL_DB, SPEAKER_LEVEL_DB, HEADPHONE_LEFT_LEVEL_DB, OSR_RATIO;
  logic [7:0] HEADPHONE_RIGHT_LEVEL_DB, LINE_LEFT_TRIM_DB, LINE_RIGHT_TRIM_DB, VOICE_TRIM_DB;
  logic [7:0] PCM_LEFT_TRIM_DB, PCM_RIGHT_TRIM_DB, SYNTH_REF_HALVES, SYNTH_FB_INT, a, m [16];
  logic [15:0] lfsr = 16'h0003;
  int         miscompares = 0;
  int         n_compared = 0;
  int         osr [4] = '{125, 128, 64, 32};
  int         vol [32] = '{-128, -56, -52, -48, -45, -42, -39, -36, -33, -30, -28, -26,
    -24, -22, -20, -18, -16, -14, -12, -10, -8, -6, -4, -3, -2, -1, 0, 1, 2, 3, 4, 5};

  assign ins = {LINE_IN_LEFT_ON, LINE_IN_RIGHT_ON, PCM_LEFT_CH_ON, PCM_RIGHT_CH_ON, MONO_IN_ON};

  argc_regs dut (.*);
  argc_spi_host host (.clk(CORE_CLK), .enb_n(SPI_ENB_N), .sck(SPI_SCK), .sdi(SPI_SDI));

  initial begin
    CORE_CLK = 1'b0;
    forever #25 CORE_CLK = ~CORE_CLK;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("compared %0d, wrong %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic check_all();
    md = m[0][3] ? m[0][2:0] : 3'h0;
    mx = (md == 3'h0) ? 2'b00 : {m[1][6] | !m[1][7], !m[1][6]};
    chk(MIXER_MODE, md);
    chk({MONO_MUX_ON, HP_MUX_ON}, mx);
    chk(CAPLESS_HP_SELECT, m[0][4]);
    chk(CAP_COUPLED_OUT, !m[0][4]);
    chk(HEADPHONE_LEFT_MUTE, mx[0] & m[0][4] & !m[1][2]);
    chk(HEADPHONE_RIGHT_MUTE, mx[0] & m[0][4] & !m[1][3]);
    if (md == 3'h0) begin
      chk({EARPIECE_ON, SPEAKER_ON, HEADPHONE_LEFT_ON, HEADPHONE_RIGHT_ON}, 8'h00);
      chk(ins, 8'h00);
    end else begin
      chk({EARPIECE_ON, SPEAKER_ON}, {mx[1] & m[1][0], mx[1] & m[1][1]});
      chk({HEADPHONE_LEFT_ON, HEADPHONE_RIGHT_ON}, {mx[0] & m[1][2], mx[0] & m[1][3]});
      if (m[1][4]) chk(ins, 8'h18);
      else if (m[1][5]) chk(ins, 8'h06);
      else chk(ins, {{2{ARGC_LINE_MODES[md]}}, {2{ARGC_PCM_MODES[md]}}, ARGC_MONO_MODES[md]});
      if (m[1][6]) chk({MONO_MUX_ON, HP_MUX_ON}, 8'h02);
      else if (m[1][7]) chk({MONO_MUX_ON, HP_MUX_ON}, 8'h01);
    end
    chk(EARPIECE_LEVEL_DB, 8'(vol[m[2][4:0]]));
    chk(SPEAKER_LEVEL_DB, 8'(vol[m[3][4:0]]));
    chk(HEADPHONE_LEFT_LEVEL_DB, 8'(vol[m[5][4:0]]));
    chk(HEADPHONE_RIGHT_LEVEL_DB, 8'(vol[m[6][4:0]]));
    chk(LINE_LEFT_TRIM_DB, 8'(3 * m[7][2:0] - 6));
    chk(LINE_RIGHT_TRIM_DB, 8'(3 * m[7][5:3] - 6));
    chk(VOICE_TRIM_DB, 8'(3 * m[8][2:0] - 12));
    chk(PCM_LEFT_TRIM_DB, 8'(3 * m[8][4:3] - 3));
    chk(PCM_RIGHT_TRIM_DB, 8'(3 * m[8][6:5] - 3));
    chk(MCLK_HALVE, m[9][0]);
    chk(SYNTH_SRC_ASI_CLK, m[9][1]);
    chk(CORE_CLK_FROM_SYNTH, m[9][2]);
    chk(SYNTH_ENABLE, m[9][3] & md[2]);
    chk(PRESCALE_HALVES, m[9][7:4] < 2 ? 8'h02 : 8'(m[9][7:4] + 1));
    chk(OSR_RATIO, 8'(osr[m[14][1:0]]));
    chk(SYNTH_REF_OFF, m[10][6:0] == 0);
    chk(SYNTH_REF_HALVES, 8'(m[10][6:0] + 1));
    chk(SYNTH_FB_OFF, m[11] == 0);
    chk(SYNTH_FB_INT, m[11] < 10 ? 8'h0A : m[11]);
    chk(SYNTH_POST_OFF, m[13][3:0] == 0);
    chk(SYNTH_POST_HALVES, 8'(m[13][3:0] + 1));
    chk(SYNTH_FRACTION, m[12][4:0]);
  endtask : check_all

  initial begin
    repeat (100000) @(posedge CORE_CLK);
    miscompares++;
    report_and_stop();
  end

  initial begin
    RESET = 1'b1;
    foreach (m[i]) m[i] = 8'h00;
    repeat (20) @(posedge CORE_CLK);
    #1 RESET = 1'b0;
    check_all();
    for (int k = 0; k < 300; k++) begin
      lfsr = lfsr_next(lfsr);
      a = (lfsr[12:11] == 2'b00) ? lfsr[15:8] : {4'h0, lfsr[3:0]};
      if (lfsr[10:8] == 3'h0) begin
        lfsr = lfsr_next(lfsr);
        host.send({a, lfsr[7:0]}, 9);
      end else begin
        lfsr = lfsr_next(lfsr);
        host.send({a, lfsr[7:0]}, 16);
        if (a[7:4] == 4'h0 && a[3:0] != 4'h4 && a[3:0] != 4'hF) m[a[3:0]] = lfsr[7:0];
      end
      check_all();
    end
    report_and_stop();
  end
endmodule : tb_audio_route_gain_clock_regs
